// >>> src/switch_status_fault_readout.sv
`timescale 1ns/1ps
// Notes on behaviour
// - address 0x1f read returns switch states in the next frame
// - data bits 0..21 give one switch each, 1 closed, 0 open
// - bits 21..14 programmable inputs 7..0, bits 13..0 ground inputs
// - bit 23 is OR of all fault flags and wetting faults
// - bit 22 sets on any switch change or new fault flag
// - after power-on both summary and interrupt flag read as 1
// - any valid frame clears the interrupt flag; a frame with bad address or bit count sets it instead
// - persisting fault raises no new interrupt until it ends and recurs
// - summary from latched fault flags stays set until the fault word is read; a wetting fault sets it only while present
// - bits 23,22 in every response except link check and wetting config; bit 23 reads 0 in the fault word
// - interrupt output released 1.0 ms after select falls
// - a cleared flag whose cause persists is set again at once
// - fault word layout with unused bits reading zero
// - frame error sets on bad address or bit count
// - checksum fault clears only when mismatch gone and read
// - supply and thermal flags clear when condition ended and read
// - wake flags latch the wake cause and clear on read
// - power-on flag set by reset, cleared on read
// - first frame after low power returns both flags as 1
module switch_status_fault_readout #(
   parameter int INT_RELEASE_CYC = msdi_pkg::INT_RELEASE_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        sclk,
   input  wire logic        chip_select_low,
   input  wire logic        mosi,
   output logic             miso,
   output logic             miso_oe,
   input  wire logic [13:0] ground_switch_inputs,
   input  wire logic [7:0]  programmable_switch_inputs,
   input  wire logic        undervoltage_in,
   input  wire logic        overvoltage_in,
   input  wire logic        thermal_warning_in,
   input  wire logic        overtemperature_in,
   input  wire logic        checksum_mismatch_in,
   input  wire logic        wetting_fault_in,
   input  wire logic        low_power_state,
   input  wire logic        wake_by_interrupt,
   input  wire logic        wake_by_pin,
   input  wire logic        wake_by_spi,
   output logic             interrupt_out_n
);
   localparam int CW = msdi_pkg::FRAME_BITS;

   typedef enum logic [1:0] {IDLE, SHIFT, DONE} link_e;

   logic [25:0] async_in;
   logic [25:0] sync_in;
   logic        sclk_s;
   logic        cs_s;
   logic        mosi_s;
   logic [3:0]  cond_s;
   logic        chk_s;
   logic        wetf_s;
   logic        lps_s;
   logic [2:0]  wake_s;

   sync2 #(.W(3), .INIT(3'h2)) u_link_sync ( // select idles high
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({sclk, chip_select_low, mosi}),
      .q     ({sclk_s, cs_s, mosi_s})
   );

   assign async_in = {programmable_switch_inputs, ground_switch_inputs,
                      undervoltage_in, overvoltage_in, thermal_warning_in,
                      overtemperature_in};

   sync2 #(.W(26)) u_in_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (async_in),
      .q     (sync_in)
   );

   sync2 #(.W(6)) u_misc_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({checksum_mismatch_in, wetting_fault_in, low_power_state,
               wake_by_interrupt, wake_by_pin, wake_by_spi}),
      .q     ({chk_s, wetf_s, lps_s, wake_s})
   );

   logic [21:0] sw_now;
   assign sw_now = sync_in[25:4];
   assign cond_s = sync_in[3:0];

   // link state
   link_e            st_q, st_d;
   logic             sclk_q, sclk_d, cs_q, cs_d;
   logic [CW-1:0]    rx_q, rx_d;
   logic [23:0]      tx_q, tx_d;
   logic [5:0]       cnt_q, cnt_d;
   logic [6:0]       prev_addr_q, prev_addr_d;
   logic             prev_rd_q, prev_rd_d;
   logic             miso_q, miso_d;
   logic [21:0]      sw_q, sw_d;
   logic             int_q, int_d;
   logic             wake_q, wake_d;
   logic             lps_q, lps_d;
   logic [31:0]      tmr_q, tmr_d;
   logic             int_out_q, int_out_d;
   logic [3:0]       cond_q, cond_d;

   logic cs_fall, cs_rise, sclk_rise, sclk_fall;
   logic frame_ok, frame_bad, fault_read;
   localparam int FLAG_W = msdi_pkg::FLAG_N;
   logic [FLAG_W-1:0] flags;
   logic [FLAG_W-1:0] fset, fhold;
   logic fsum;

   assign cs_fall   = cs_q & ~cs_s;
   assign cs_rise   = ~cs_q & cs_s;
   assign sclk_rise = ~sclk_q & sclk_s;
   assign sclk_fall = sclk_q & ~sclk_s;

   function automatic logic addr_valid(input logic [6:0] a);
      addr_valid = (a != 7'h00) && (a <= msdi_pkg::ADDR_MAX);
   endfunction : addr_valid

   assign frame_ok   = cs_rise && (st_q == SHIFT) && (cnt_q == 6'h20)
                       && addr_valid(rx_q[31:25]);
   assign frame_bad  = cs_rise && (st_q == SHIFT)
                       && !((cnt_q == 6'h20) && addr_valid(rx_q[31:25]));
   // fault word reaches host in the frame after its address
   assign fault_read = cs_rise && (st_q == SHIFT) && (cnt_q == 6'h20)
                       && prev_rd_q
                       && (prev_addr_q == msdi_pkg::ADDR_FAULT_FLAG);

   // flag sets and holds, bit order per fault word
   always_comb begin
      fset  = '0;
      fhold = '0;
      fset[10]  = frame_bad;
      fset[9]   = chk_s;
      fhold[9]  = chk_s;
      fset[8:5] = cond_s;
      fhold[8:5]= cond_s;
      fset[4:2] = {3{lps_q & ~lps_s}} & wake_s;
      fset[1]   = 1'b0;
      fset[0]   = 1'b0;
   end

   flag_latch #(.W(FLAG_W), .INIT(msdi_pkg::FLAGS_RESET)) u_flags (
      .clk   (clk),
      .rst_b (rst_b),
      .set   (fset),
      .hold  (fhold),
      .clr   (fault_read),
      .q     (flags)
   );

   assign fsum = (|flags) | wetf_s;

   function automatic logic [23:0] fault_word(input logic [10:0] f,
                                              input logic i);
      fault_word = '0;
      fault_word[msdi_pkg::INT_FLAG_POS]  = i;
      fault_word[msdi_pkg::FRAME_ERR_POS] = f[10];
      fault_word[msdi_pkg::CHECKSUM_POS]  = f[9];
      fault_word[7:4] = f[8:5];
      fault_word[3:1] = f[4:2];
      fault_word[0]   = f[0];
   endfunction : fault_word

   always_comb begin
      st_d        = st_q;
      sclk_d      = sclk_s;
      cs_d        = cs_s;
      rx_d        = rx_q;
      tx_d        = tx_q;
      cnt_d       = cnt_q;
      prev_addr_d = prev_addr_q;
      prev_rd_d   = prev_rd_q;
      miso_d      = miso_q;
      cond_d      = cond_s;
      lps_d       = lps_s;
      sw_d        = sw_q;
      wake_d      = wake_q;
      int_d       = int_q;
      if (st_q == IDLE)
         sw_d = sw_now;
      case (st_q)
         IDLE: begin
            if (cs_fall) begin
               st_d  = SHIFT;
               cnt_d = '0;
               tx_d  = '0;
               if (!(prev_rd_q && prev_addr_q == msdi_pkg::ADDR_FAULT_FLAG))
                  tx_d[21:0] = sw_q;
               else
                  tx_d = fault_word(flags, int_q | wake_q);
               if (!(prev_addr_q == msdi_pkg::ADDR_LINK_CHECK
                     || prev_addr_q == msdi_pkg::ADDR_WET_CONFIG)) begin
                  tx_d[23] = fsum | wake_q;
                  tx_d[22] = int_q | wake_q;
               end
               if (prev_rd_q && prev_addr_q == msdi_pkg::ADDR_FAULT_FLAG)
                  tx_d[23] = 1'b0;
               miso_d = 1'b0;
            end
         end
         SHIFT: begin
            if (cs_cycle_start(cnt_q, sclk_rise))
               miso_d = 1'b0;
            if (sclk_rise && cnt_q != 6'h3f) begin
               rx_d  = {rx_q[CW-2:0], mosi_s};
               cnt_d = cnt_q + 6'h01;
            end
            if (sclk_fall && !cs_cycle_start(cnt_q, sclk_fall)) begin
               miso_d = tx_q[23];
               tx_d   = {tx_q[22:0], 1'b0};
            end
            if (cs_rise) begin
               st_d = IDLE;
               if (frame_ok) begin
                  prev_addr_d = rx_q[31:25];
                  prev_rd_d   = ~rx_q[24];
                  int_d       = 1'b0;
                  wake_d      = 1'b0;
               end
            end
         end
         default: st_d = IDLE;
      endcase
      // new events win over a read clear in the same cycle
      if ((sw_now != sw_q && st_q == IDLE) || (|(cond_s & ~cond_q))
          || frame_bad || (chk_s && !flags[9]))
         int_d = 1'b1;
      if (lps_q & ~lps_s)
         wake_d = 1'b1;
   end

   // address bits travel ahead of data, so miso idles low until data
   function automatic logic cs_cycle_start(input logic [5:0] c,
                                           input logic r);
      cs_cycle_start = r && (c < 6'd8);
   endfunction : cs_cycle_start

   always_comb begin
      int_out_d = int_out_q;
      tmr_d     = tmr_q;
      if (int_q && !int_out_q && tmr_q == '0)
         int_out_d = 1'b1;
      if (cs_fall && int_out_q)
         tmr_d = 32'(INT_RELEASE_CYC);
      if (tmr_q != '0) begin
         tmr_d = tmr_q - 32'd1;
         if (tmr_q == 32'd1)
            int_out_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q        <= IDLE;
         sclk_q      <= 1'b0;
         cs_q        <= 1'b1;
         rx_q        <= '0;
         tx_q        <= '0;
         cnt_q       <= '0;
         prev_addr_q <= msdi_pkg::ADDR_SWITCH_STATE;
         prev_rd_q   <= 1'b1;
         miso_q      <= 1'b0;
         sw_q        <= '0;
         int_q       <= 1'b1;
         wake_q      <= 1'b0;
         lps_q       <= 1'b0;
         tmr_q       <= '0;
         int_out_q   <= 1'b0;
         cond_q      <= '0;
      end else begin
         st_q        <= st_d;
         sclk_q      <= sclk_d;
         cs_q        <= cs_d;
         rx_q        <= rx_d;
         tx_q        <= tx_d;
         cnt_q       <= cnt_d;
         prev_addr_q <= prev_addr_d;
         prev_rd_q   <= prev_rd_d;
         miso_q      <= miso_d;
         sw_q        <= sw_d;
         int_q       <= int_d;
         wake_q      <= wake_d;
         lps_q       <= lps_d;
         tmr_q       <= tmr_d;
         int_out_q   <= int_out_d;
         cond_q      <= cond_d;
      end
   end

   assign miso            = miso_q;
   assign miso_oe         = (st_q == SHIFT);
   assign interrupt_out_n = ~int_out_q;
endmodule : switch_status_fault_readout

// >>> src/msdi_pkg.sv
package msdi_pkg;
   // frame layout
   localparam int FRAME_BITS   = 32;
   localparam int ADDR_HI      = 31;
   localparam int ADDR_LO      = 25;
   localparam int RW_BIT       = 24;
   localparam int DATA_BITS    = 24;
   localparam int CNT_W        = 6;
   // register addresses
   localparam logic [6:0] ADDR_SWITCH_STATE = 7'h1f;
   localparam logic [6:0] ADDR_FAULT_FLAG   = 7'h21;
   localparam logic [6:0] ADDR_LINK_CHECK   = 7'h01;
   localparam logic [6:0] ADDR_WET_CONFIG   = 7'h02;
   localparam logic [6:0] ADDR_MAX          = 7'h24;
   // response field positions
   localparam int FAULT_SUM_POS = 23;
   localparam int INT_FLAG_POS  = 22;
   localparam int SWITCH_N      = 22;
   localparam int GROUND_N      = 14;
   localparam int PROG_N        = 8;
   // fault word positions
   localparam int FRAME_ERR_POS = 10;
   localparam int CHECKSUM_POS  = 9;
   localparam int UNDERV_POS    = 7;
   localparam int OVERV_POS     = 6;
   localparam int THERM_POS     = 5;
   localparam int OVERT_POS     = 4;
   localparam int WAKE_INT_POS  = 3;
   localparam int WAKE_PIN_POS  = 2;
   localparam int WAKE_SPI_POS  = 1;
   localparam int POR_POS       = 0;
   localparam int FLAG_N        = 11;
   // reset values
   localparam logic [FLAG_N-1:0] FLAGS_RESET = 11'h001;
   // interrupt release delay
   localparam real CLK_MHZ          = 200.0;
   localparam real INT_RELEASE_US   = 1000.0;
   localparam int  INT_RELEASE_CYC  = int'(INT_RELEASE_US * CLK_MHZ);
endpackage : msdi_pkg

// >>> src/sync2.sv
`timescale 1ns/1ps
module sync2 #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] m_q;
   logic [W-1:0] m_d;
   logic [W-1:0] q_d;

   always_comb begin
      m_d = d;
      q_d = m_q;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         m_q <= INIT;
         q   <= INIT;
      end else begin
         m_q <= m_d;
         q   <= q_d;
      end
   end
endmodule : sync2

// >>> src/flag_latch.sv
`timescale 1ns/1ps
// latched flag: sets on event, clears on read unless the cause persists
module flag_latch #(
   parameter int  W      = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] hold,
   input  wire logic         clr,
   output logic      [W-1:0] q
);
   logic [W-1:0] q_d;

   always_comb begin
      q_d = clr ? (set | hold) : (q | set);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= INIT;
      end else begin
         q <= q_d;
      end
   end
endmodule : flag_latch

// >>> sim/switch_status_fault_readout_props.sv
`timescale 1ns/1ps
module switch_status_fault_readout_props #(
   parameter int INT_RELEASE_CYC = 50
) (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        sclk,
   input wire logic        chip_select_low,
   input wire logic        miso,
   input wire logic        miso_oe,
   input wire logic [13:0] ground_switch_inputs,
   input wire logic [7:0]  programmable_switch_inputs,
   input wire logic        undervoltage_in,
   input wire logic        overvoltage_in,
   input wire logic        thermal_warning_in,
   input wire logic        overtemperature_in,
   input wire logic        checksum_mismatch_in,
   input wire logic        wetting_fault_in,
   input wire logic        low_power_state,
   input wire logic        interrupt_out_n
);
   localparam int REL_MAX = INT_RELEASE_CYC + 8;
   logic [29:0] ev;
   logic [29:0] ev_q;
   logic [3:0]  quiet_q;
   logic [3:0]  quiet_d;
   assign ev = {ground_switch_inputs, programmable_switch_inputs,
                undervoltage_in, overvoltage_in, thermal_warning_in,
                overtemperature_in, checksum_mismatch_in,
                wetting_fault_in, low_power_state, chip_select_low};
   // idle cycles with no event input moving
   always_comb begin
      quiet_d = quiet_q + 4'h1;
      if (ev != ev_q || !chip_select_low)
         quiet_d = 4'h0;
      else if (&quiet_q)
         quiet_d = quiet_q;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         quiet_q <= 4'h0;
         ev_q    <= '0;
      end else begin
         quiet_q <= quiet_d;
         ev_q    <= ev;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   por_int_a: assert property (
      $rose(rst_b) |-> ##[0:3] !interrupt_out_n)
      else $error("interrupt not raised after reset");
   rel_a: assert property (
      $fell(chip_select_low) && !interrupt_out_n
      |-> ##[1:REL_MAX] interrupt_out_n)
      else $error("interrupt output not released");
   early_a: assert property (
      $fell(chip_select_low) && !interrupt_out_n
      |-> ##1 !interrupt_out_n [*8])
      else $error("interrupt output released early");
   hold_int_a: assert property (
      chip_select_low && !interrupt_out_n |=> !interrupt_out_n)
      else $error("interrupt output released without a frame");
   oe_on_a: assert property (
      $fell(chip_select_low) |-> ##[1:5] miso_oe)
      else $error("miso not driven in frame");
   oe_off_a: assert property (
      chip_select_low [*6] |-> !miso_oe)
      else $error("miso driven outside frame");
   miso_edge_a: assert property (
      $changed(miso) && !chip_select_low |-> !sclk)
      else $error("miso moved while serial clock high");
   quiet_int_a: assert property (
      quiet_q > 4'hb |-> !$fell(interrupt_out_n))
      else $error("interrupt raised with no new event");
   cover property ($fell(chip_select_low));
   cover property ($rose(interrupt_out_n));
   cover property ($fell(interrupt_out_n) && chip_select_low);
endmodule : switch_status_fault_readout_props

bind switch_status_fault_readout switch_status_fault_readout_props
   #(.INT_RELEASE_CYC(INT_RELEASE_CYC)) u_props (
   .clk                        (clk),
   .rst_b                      (rst_b),
   .sclk                       (sclk),
   .chip_select_low            (chip_select_low),
   .miso                       (miso),
   .miso_oe                    (miso_oe),
   .ground_switch_inputs       (ground_switch_inputs),
   .programmable_switch_inputs (programmable_switch_inputs),
   .undervoltage_in            (undervoltage_in),
   .overvoltage_in             (overvoltage_in),
   .thermal_warning_in         (thermal_warning_in),
   .overtemperature_in         (overtemperature_in),
   .checksum_mismatch_in       (checksum_mismatch_in),
   .wetting_fault_in           (wetting_fault_in),
   .low_power_state            (low_power_state),
   .interrupt_out_n            (interrupt_out_n)
);

// >>> sim/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
   output logic      sclk,
   output logic      chip_select_low,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe
);
   initial begin
      sclk            = 1'b0;
      chip_select_low = 1'b1;
      mosi            = 1'b0;
   end
   // one frame: select falls, n clocks msb first, select rises
   task automatic xfer(input logic [31:0] w, input int n,
                       output logic [23:0] r);
      logic [31:0] s;
      s = '0;
      // edges kept off the clock grid
      #60.2 chip_select_low = 1'b0;
      for (int i = 0; i < n; i++) begin
         mosi = w[31-i];
         #24 sclk = 1'b1;
         // a released line reads as the inverse
         s = {s[30:0], miso_oe ? miso : ~miso};
         #24 sclk = 1'b0;
      end
      mosi = ~mosi;
      #59.8 chip_select_low = 1'b1;
      #200;
      r = s[23:0];
   endtask : xfer
endmodule : spi_host_model

// >>> sim/tb_switch_status_fault_readout.sv
`timescale 1ns/1ps
module tb_switch_status_fault_readout;
   localparam logic [6:0]  SW  = msdi_pkg::ADDR_SWITCH_STATE;
   localparam logic [6:0]  FLT = msdi_pkg::ADDR_FAULT_FLAG;
   localparam logic [21:0] S1  = {8'ha5, 14'h1234};
   localparam logic [21:0] S2  = {8'h5a, 14'h0dcb};
   logic        clk, rst_b, sclk, chip_select_low, mosi, miso, miso_oe;
   logic        interrupt_out_n, wetting_fault_in, low_power_state;
   logic [13:0] ground_switch_inputs;
   logic [7:0]  programmable_switch_inputs;
   logic        undervoltage_in, overvoltage_in, thermal_warning_in;
   logic        overtemperature_in, checksum_mismatch_in;
   logic        wake_by_interrupt, wake_by_pin, wake_by_spi;
   logic [4:0]  flt;
   logic [2:0]  wk;
   logic [23:0] r;
   int          num_errors, cmp_count;
   int          pos [5] = '{9, 4, 5, 6, 7};
   assign {undervoltage_in, overvoltage_in, thermal_warning_in,
           overtemperature_in, checksum_mismatch_in} = flt;
   assign {wake_by_interrupt, wake_by_pin, wake_by_spi} = wk;
   switch_status_fault_readout #(.INT_RELEASE_CYC(50)) u_dut (
      .clk                        (clk),
      .rst_b                      (rst_b),
      .sclk                       (sclk),
      .chip_select_low            (chip_select_low),
      .mosi                       (mosi),
      .miso                       (miso),
      .miso_oe                    (miso_oe),
      .ground_switch_inputs       (ground_switch_inputs),
      .programmable_switch_inputs (programmable_switch_inputs),
      .undervoltage_in            (undervoltage_in),
      .overvoltage_in             (overvoltage_in),
      .thermal_warning_in         (thermal_warning_in),
      .overtemperature_in         (overtemperature_in),
      .checksum_mismatch_in       (checksum_mismatch_in),
      .wetting_fault_in           (wetting_fault_in),
      .low_power_state            (low_power_state),
      .wake_by_interrupt          (wake_by_interrupt),
      .wake_by_pin                (wake_by_pin),
      .wake_by_spi                (wake_by_spi),
      .interrupt_out_n            (interrupt_out_n)
   );
   spi_host_model u_host (
      .sclk            (sclk),
      .chip_select_low (chip_select_low),
      .mosi            (mosi),
      .miso            (miso),
      .miso_oe         (miso_oe)
   );
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic check(input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("FAIL response exp %h got %h", e, g);
      end
   endtask : check
   task automatic fr(input logic [6:0] a, input logic [23:0] e,
                     input logic [23:0] m = 24'hffffff);
      u_host.xfer({a, 1'b0, 24'h0}, 32, r);
      check(e & m, r & m);
   endtask : fr
   task automatic settle();
      repeat (12) @(posedge clk);
   endtask : settle
   initial begin
      #400000;
      num_errors++;
      summarize();
   end
   initial begin
      rst_b = 1'b0;
      {programmable_switch_inputs, ground_switch_inputs} = S1;
      flt = '0;
      wk = '0;
      wetting_fault_in = 1'b0;
      low_power_state = 1'b0;
      num_errors = 0;
      cmp_count = 0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
      fr(SW, {2'b11, S1});
      fr(SW, {2'b10, S1});
      @(posedge clk) {programmable_switch_inputs, ground_switch_inputs} <= S2;
      settle();
      fr(FLT, {2'b11, S2});
      fr(SW, 24'h000001);
      fr(SW, {2'b00, S2});
      for (int i = 0; i < 5; i++) begin
         @(posedge clk) flt <= 5'h01 << i;
         settle();
         fr(FLT, {2'b11, S2});
         fr(FLT, 24'h1 << pos[i]);
         @(posedge clk) flt <= '0;
         settle();
         fr(SW, 24'h1 << pos[i]);
         fr(SW, {2'b00, S2});
      end
      @(posedge clk) flt <= 5'h02;
      settle();
      fr(FLT, {2'b11, S2});
      @(posedge clk) flt <= '0;
      settle();
      fr(SW, 24'h000010);
      u_host.xfer(32'h0, 31, r);
      fr(FLT, {2'b11, S2});
      fr(SW, 24'h000400);
      fr(SW, {2'b00, S2});
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         wk <= 3'h1 << i;
         low_power_state <= 1'b1;
         settle();
         low_power_state <= 1'b0;
         settle();
         fr(FLT, {2'b11, S2});
         fr(SW, 24'h2 << i);
         fr(SW, {2'b00, S2});
      end
      @(posedge clk) wetting_fault_in <= 1'b1;
      settle();
      fr(SW, 24'h800000, 24'h800000);
      fr(msdi_pkg::ADDR_LINK_CHECK, 24'h800000, 24'h800000);
      fr(SW, {2'b00, S2});
      summarize();
   end
endmodule : tb_switch_status_fault_readout
